//--- core/asr_host.sv
`timescale 1ns/10ps
module asr_host
    import asr_pkg::*;
#(
    parameter int ADDR_W = ASR_ADDR_W,
    parameter int DATA_W = ASR_DATA_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // user request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    // user answer
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    // memory pins
    output logic [ADDR_W-1:0] address_pins,
    output logic select_n,
    output logic write_strobe_n,
    output logic output_drive_n,
    input wire logic [DATA_W-1:0] data_pins_in,
    output logic [DATA_W-1:0] data_pins_out,
    output logic data_pins_oe_n
);

    // ----------------------------------------
    // state and counters
    // ----------------------------------------
    asr_state_t state_ff;
    asr_state_t nxt_state;
    logic [3:0] cnt_ff;
    logic cnt_done;
    logic wr_ff;

    assign cnt_done = (cnt_ff == ASR_CNT_RESET);
    // ready is combinational so a request is taken on the first idle edge
    assign req_ready = (state_ff == ASR_IDLE);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ASR_IDLE: begin
                if (req_valid) begin
                    nxt_state = req_write ? ASR_WR_SETUP : ASR_RD_SETUP;
                end
            end
            ASR_RD_SETUP: nxt_state = ASR_RD_WAIT;
            ASR_RD_WAIT: begin
                if (cnt_done) begin
                    nxt_state = ASR_RD_DONE;
                end
            end
            ASR_RD_DONE: nxt_state = ASR_RECOVER;
            ASR_WR_SETUP: nxt_state = ASR_WR_PULSE;
            ASR_WR_PULSE: begin
                if (cnt_done) begin
                    nxt_state = ASR_WR_END;
                end
            end
            ASR_WR_END: nxt_state = ASR_RECOVER;
            ASR_RECOVER: begin
                if (cnt_done) begin
                    nxt_state = ASR_IDLE;
                end
            end
            default: nxt_state = ASR_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= ASR_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // one counter times access, strobe width and bus turnaround
    // at this clock each least time fits in one count; a faster clock needs larger counts
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= ASR_CNT_RESET;
        end else if (state_ff == ASR_RD_SETUP) begin
            cnt_ff <= ASR_READ_WAIT - 4'h1;
        end else if (state_ff == ASR_WR_SETUP) begin
            cnt_ff <= ASR_WRITE_WAIT - 4'h1;
        end else if (state_ff == ASR_RD_DONE || state_ff == ASR_WR_END) begin
            cnt_ff <= ASR_RELEASE_WAIT - 4'h1;
        end else if (!cnt_done) begin
            cnt_ff <= cnt_ff - 4'h1;
        end
    end

    // ----------------------------------------
    // address and data latches
    // ----------------------------------------
    // address moves only in idle, where strobe is high and select is off
    always_ff @(posedge clk) begin
        if (rst) begin
            address_pins <= '0;
            wr_ff <= 1'b0;
        end else if (state_ff == ASR_IDLE && req_valid) begin
            address_pins <= req_addr;
            wr_ff <= req_write;
        end
    end

    // write byte is set up with the address, a whole cycle ahead of the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            data_pins_out <= '0;
        end else if (state_ff == ASR_IDLE && req_valid) begin
            data_pins_out <= req_wdata;
        end
    end

    // ----------------------------------------
    // state decoding
    // ----------------------------------------
    function automatic logic rd_state(input asr_state_t s);
        return s inside {ASR_RD_SETUP, ASR_RD_WAIT, ASR_RD_DONE};
    endfunction : rd_state

    function automatic logic wr_state(input asr_state_t s);
        return s inside {ASR_WR_SETUP, ASR_WR_PULSE, ASR_WR_END};
    endfunction : wr_state

    // select spans setup through end so it brackets the whole strobe pulse
    function automatic logic sel_state(input asr_state_t s);
        return rd_state(s) || wr_state(s);
    endfunction : sel_state

    // ----------------------------------------
    // pin controls
    // ----------------------------------------
    // pins follow the next state so each changes on the edge that enters it
    always_ff @(posedge clk) begin
        if (rst) begin
            select_n <= 1'b1;
        end else begin
            select_n <= !sel_state(nxt_state);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            write_strobe_n <= 1'b1;
        end else begin
            write_strobe_n <= (nxt_state != ASR_WR_PULSE);
        end
    end

    // output drive stays high through a write, so the bus never has two drivers
    always_ff @(posedge clk) begin
        if (rst) begin
            output_drive_n <= 1'b1;
        end else begin
            output_drive_n <= !rd_state(nxt_state);
        end
    end

    // drive data from setup to one cycle after strobe rises, so hold is above zero
    always_ff @(posedge clk) begin
        if (rst) begin
            data_pins_oe_n <= 1'b1;
        end else begin
            data_pins_oe_n <= !wr_state(nxt_state);
        end
    end

    // ----------------------------------------
    // read answer
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= (state_ff == ASR_RD_DONE) && !wr_ff;
        end
    end

    // sampled three cycles after select and drive fall, past both access times
    always_ff @(posedge clk) begin
        if (rst) begin
            rsp_rdata <= '0;
        end else if (state_ff == ASR_RD_DONE) begin
            rsp_rdata <= data_pins_in;
        end
    end

endmodule : asr_host

//--- core/asr_pkg.sv
package asr_pkg;
    // ----------------------------------------
    // geometry
    // ----------------------------------------
    localparam int ASR_ADDR_W = 15;
    localparam int ASR_DATA_W = 8;
    localparam int ASR_WORDS = 32768;
    // ----------------------------------------
    // timing in ns, fast (55) and slow (70) grades
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int READ_CYCLE_MIN_NS_FAST = 55;
    localparam int READ_CYCLE_MIN_NS_SLOW = 70;
    localparam int OUTPUT_DRIVE_ACCESS_DELAY_NS_FAST = 30;
    localparam int OUTPUT_DRIVE_ACCESS_DELAY_NS_SLOW = 50;
    localparam int WRITE_PULSE_MIN_NS_FAST = 40;
    localparam int WRITE_PULSE_MIN_NS_SLOW = 50;
    localparam int DATA_SETUP_TO_WRITE_END_NS_FAST = 20;
    localparam int DATA_SETUP_TO_WRITE_END_NS_SLOW = 30;
    localparam int UNDRIVE_TO_HIGH_IMPEDANCE_NS = 30;
    localparam int DESELECT_TO_HIGH_IMPEDANCE_NS = 35;
    // ----------------------------------------
    // cycle counts: least times round up, never below one cycle
    // ----------------------------------------
    function automatic int asr_cycles_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : asr_cycles_up

    localparam int READ_CYCLE_MIN_CYC = asr_cycles_up(READ_CYCLE_MIN_NS_SLOW);
    localparam int WRITE_PULSE_MIN_CYC = asr_cycles_up(WRITE_PULSE_MIN_NS_SLOW);
    localparam int DATA_SETUP_CYC = asr_cycles_up(DATA_SETUP_TO_WRITE_END_NS_SLOW);
    localparam int RELEASE_CYC = asr_cycles_up(DESELECT_TO_HIGH_IMPEDANCE_NS);
    localparam logic [3:0] ASR_READ_WAIT = 4'(READ_CYCLE_MIN_CYC);
    localparam logic [3:0] ASR_WRITE_WAIT = 4'(WRITE_PULSE_MIN_CYC);
    localparam logic [3:0] ASR_RELEASE_WAIT = 4'(RELEASE_CYC);
    localparam logic [3:0] ASR_CNT_RESET = 4'h0;

    typedef enum logic [2:0] {
        ASR_IDLE, ASR_RD_SETUP, ASR_RD_WAIT, ASR_RD_DONE,
        ASR_WR_SETUP, ASR_WR_PULSE, ASR_WR_END, ASR_RECOVER
    } asr_state_t;
endpackage : asr_pkg

//--- test/asr_host_properties.sv
`timescale 1ns/10ps
module asr_host_properties #(parameter int ADDR_W = 15, parameter int DATA_W = 8) (
    // clock, reset, user side
    input wire logic clk, rst, req_valid, req_ready, req_write, rsp_valid,
    input wire logic [ADDR_W-1:0] req_addr, address_pins,
    input wire logic [DATA_W-1:0] req_wdata, rsp_rdata, data_pins_in, data_pins_out,
    // memory strobes
    input wire logic select_n, write_strobe_n, output_drive_n, data_pins_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic take = req_valid && req_ready;
    AST_STANDBY: assert property (select_n |-> write_strobe_n && output_drive_n)
        else $error("strobes active while deselected");
    AST_STRB_IN_SEL: assert property (!write_strobe_n |-> !select_n)
        else $error("write strobe outside select");
    AST_NO_FIGHT: assert property (!data_pins_oe_n |-> output_drive_n)
        else $error("host drives while device may drive");
    AST_RD_STRB_HI: assert property (!output_drive_n |-> write_strobe_n)
        else $error("write strobe low in read");
    AST_ADDR_HOLD: assert property (!select_n && $past(!select_n) |-> $stable(address_pins))
        else $error("address moved while selected");
    AST_RD_SEQ: assert property (take && !req_write |=> address_pins == $past(req_addr)
        ##0 (!select_n && !output_drive_n)[*3] ##1 select_n) else $error("read pin walk");
    AST_RD_ANSWER: assert property (take && !req_write |-> ##4 rsp_valid ##1 !rsp_valid)
        else $error("read answer timing");
    AST_WR_SEQ: assert property (take && req_write |=> (data_pins_out == $past(req_wdata)
        && !data_pins_oe_n && !select_n && write_strobe_n) ##1 !write_strobe_n
        ##1 (write_strobe_n && !data_pins_oe_n) ##1 select_n) else $error("write pin walk");
    AST_BUSY: assert property (!select_n |-> !req_ready)
        else $error("ready while busy");
    C_WR: cover property (take && req_write);
    C_RD: cover property (take && !req_write);
    C_ANS: cover property (rsp_valid);
endmodule : asr_host_properties
bind asr_host asr_host_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (.clk, .rst,
    .req_valid, .req_ready, .req_write, .rsp_valid, .req_addr, .address_pins, .req_wdata,
    .rsp_rdata, .data_pins_in, .data_pins_out, .select_n, .write_strobe_n, .output_drive_n,
    .data_pins_oe_n);

//--- test/asr_sram_model.sv
`timescale 1ns/10ps
module asr_sram_model #(parameter int ACCESS_NS = 70, parameter int HOLD_NS = 10) (
    input wire logic [14:0] address_pins,
    input wire logic select_n, write_strobe_n, output_drive_n, data_pins_oe_n,
    input wire logic [7:0] data_pins_out,
    output logic [7:0] data_pins_in
);
    logic [7:0] mem [32768];
    logic ok = 1'b0;
    logic flip = 1'b0;
    logic [7:0] q = 8'h00;
    wire logic drv = !select_n && write_strobe_n && !output_drive_n;
    // a floating wire shows a moving pattern, so a stale byte never passes for data
    always #50 flip = ~flip;
    // old byte lingers a hold time, the new one shows a full access after any change
    always @(address_pins, select_n, write_strobe_n, output_drive_n) begin
        #(HOLD_NS) ok = 1'b0;
        #(ACCESS_NS - HOLD_NS);
        q = mem[address_pins];
        ok = drv;
    end
    assign data_pins_in = !data_pins_oe_n ? data_pins_out : (drv && ok) ?
        q : {8{flip}} ^ 8'ha5;
    always @(posedge write_strobe_n or posedge select_n) begin
        if (!select_n || !write_strobe_n) mem[address_pins] = data_pins_in;
    end
endmodule : asr_sram_model

//--- test/test_asr_host.sv
`timescale 1ns/10ps
module test_asr_host;
    logic clk, rst, req_valid, req_write;
    logic [14:0] req_addr;
    logic [7:0] req_wdata;
    wire logic req_ready, rsp_valid, select_n, write_strobe_n, output_drive_n, data_pins_oe_n;
    wire logic [14:0] address_pins;
    wire logic [7:0] rsp_rdata, data_pins_in, data_pins_out;
    int n_mismatch = 0;
    int checks = 0;
    asr_host dut (.clk, .rst, .req_valid, .req_ready, .req_write, .req_addr, .req_wdata,
        .rsp_valid, .rsp_rdata, .address_pins, .select_n, .write_strobe_n, .output_drive_n,
        .data_pins_in, .data_pins_out, .data_pins_oe_n);
    asr_sram_model mem_side (.address_pins, .select_n, .write_strobe_n, .output_drive_n,
        .data_pins_oe_n, .data_pins_out, .data_pins_in);
    task automatic chk(input logic [14:0] seen, input logic [14:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        if (n_mismatch == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic req(input logic w, input logic [14:0] a, input logic [7:0] d);
        int n = 0;
        @(negedge clk);
        {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk(req_ready, 1'b1);
        @(negedge clk);
        req_valid = 1'b0;
        chk(req_ready, 1'b0);
    endtask : req
    task automatic rd(input logic [14:0] a, input logic [7:0] exp);
        int n = 0;
        req(1'b0, a, 8'h00);
        while (rsp_valid !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        chk(15'(n), 15'h3);
        chk(rsp_rdata, exp);
    endtask : rd
    task automatic t_edges();
        req(1'b1, 15'h0000, 8'h3c);
        req(1'b1, 15'h7fff, 8'hc3);
        req(1'b1, 15'h1234, 8'ha5);
        rd(15'h7fff, 8'hc3);
        rd(15'h0000, 8'h3c);
        rd(15'h1234, 8'ha5);
    endtask : t_edges
    task automatic t_next_addr();
        req(1'b1, 15'h0000, 8'h5a);
        rd(15'h7fff, 8'hc3);
        rd(15'h0000, 8'h5a);
    endtask : t_next_addr
    task automatic t_abort();
        req(1'b1, 15'h1234, 8'h00);
        rst = 1'b1;
        @(negedge clk);
        chk({select_n, write_strobe_n, data_pins_oe_n}, 3'b111);
        rst = 1'b0;
        rd(15'h1234, 8'ha5);
    endtask : t_abort
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #(2000 * 100);
        n_mismatch++;
        close_out();
    end
    initial begin
        {req_valid, req_write, req_addr, req_wdata} = '0;
        rst = 1'b1;
        repeat (4) @(negedge clk);
        chk({select_n, write_strobe_n, output_drive_n, data_pins_oe_n}, 4'hf);
        rst = 1'b0;
        t_edges();
        t_next_addr();
        t_abort();
        close_out();
    end
endmodule : test_asr_host
